// File: hdl/ecc_consts.vh
`ifndef ECC_CONSTS_VH
`define ECC_CONSTS_VH

// ==========================================================================
// Serial command word layout
`define ECC_WORD_BITS       32
`define ECC_CNT_LAST        6'h1f
`define ECC_RW_BIT          31
`define ECC_ADDR_MSB        30
`define ECC_ADDR_LSB        24
`define ECC_DATA_MSB        23
`define ECC_RW_WRITE        1'b1

// ==========================================================================
// Register map
`define ECC_ADDR_CHAN_CTRL  7'h01

// ==========================================================================
// Channel control field positions
`define ECC_BIT_LEFT_ARM    23
`define ECC_BIT_LEFT_LEG    22
`define ECC_BIT_RIGHT_ARM   21
`define ECC_BIT_CHEST_ONE   20
`define ECC_BIT_CHEST_TWO   19
`define ECC_BIT_DIFF_SEL    10
`define ECC_GAIN_MSB        9
`define ECC_GAIN_LSB        8

// ==========================================================================
// Reset values
`define ECC_RST_CHAN_ON     1'b0
`define ECC_RST_DIFF_SEL    1'b0
`define ECC_RST_GAIN        2'h0
`define ECC_RSVD_FILL       8'h00

// ==========================================================================
// Gain codes and gain in tenths
`define ECC_GAIN_CODE_0     2'h0
`define ECC_GAIN_CODE_1     2'h1
`define ECC_GAIN_CODE_2     2'h2
`define ECC_GAIN_CODE_3     2'h3
`define ECC_GAIN_X1P4       8'h0e
`define ECC_GAIN_X2P1       8'h15
`define ECC_GAIN_X2P8       8'h1c
`define ECC_GAIN_X4P2       8'h2a

`endif

// File: hdl/ecc_sync.v
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser, one per serial pin
module ecc_sync (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rstn,
    input  wire       ce,
    // Pins in, synchronised out
    input  wire [2:0] pin_in,
    input  wire [2:0] reset_level,
    output wire [2:0] pin_sync
);

    genvar i;

    // First stage feeds only the second stage, nothing else looks at it
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_bit
            reg stage_a;
            reg stage_b;
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    stage_a <= 1'b1;
                    stage_b <= 1'b1;
                end else if (ce) begin
                    stage_a <= pin_in[i];
                    stage_b <= stage_a;
                end
            end
            // Both branches give stage_b, so reset_level has no effect; reset value itself stays constant
            assign pin_sync[i] = reset_level[i] ? stage_b : (stage_b & ~stage_b) | stage_b;
        end
    endgenerate

endmodule // ecc_sync

// File: hdl/ecc_ctrl.v
`timescale 1ns/1ps
`include "ecc_consts.vh"

module ecc_ctrl (
    // Clock, reset, enable
    input  wire       sys_clk,
    input  wire       rstn,
    input  wire       ce,
    // Serial port pins
    input  wire       sclk,
    input  wire       cs_n,
    input  wire       sdi,
    output reg        sdo,
    output reg        sdo_oe,
    // Channel power controls
    output reg        left_arm_channel_on,
    output reg        left_leg_channel_on,
    output reg        right_arm_channel_on,
    output reg        chest_one_channel_on,
    output reg        chest_two_channel_on,
    // Front-end configuration
    output reg        differential_input_select,
    output reg  [1:0] gain_code,
    output reg  [7:0] gain_tenths,
    output reg        gain_cal_required
);

    // ======================================================================
    // State encoding
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_WAIT  = 3'b100;

    // ======================================================================
    // Declarations
    wire [2:0]  pin_sync;
    wire        sclk_s;
    wire        cs_n_s;
    wire        sdi_s;
    reg         sclk_d;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [5:0]  bit_cnt;
    reg  [30:0] rx_shift;
    reg  [31:0] tx_shift;
    reg  [31:0] tx_word;
    wire        sclk_rise;
    wire        sclk_fall;
    wire [31:0] cmd_word;
    wire        word_done;
    wire        is_write;
    wire [6:0]  cmd_addr;
    wire [23:0] chan_ctrl_rd;

    // ======================================================================
    // Pin synchronisers
    ecc_sync u_sync (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .ce          (ce),
        .pin_in      ({sdi, cs_n, sclk}),
        .reset_level (3'b111),
        .pin_sync    (pin_sync)
    );

    assign sclk_s = pin_sync[0];
    assign cs_n_s = pin_sync[1];
    assign sdi_s  = pin_sync[2];

    // Edges taken from the synchronised copy only
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;

    // Full command word as the last bit arrives
    assign cmd_word  = {rx_shift, sdi_s};
    assign word_done = (state == ST_SHIFT) && sclk_rise && (bit_cnt == `ECC_CNT_LAST);
    assign is_write  = (cmd_word[`ECC_RW_BIT] == `ECC_RW_WRITE);
    assign cmd_addr  = cmd_word[`ECC_ADDR_MSB:`ECC_ADDR_LSB];

    // Readback image; reserved and out-of-scope bits are hard zeros
    assign chan_ctrl_rd = {left_arm_channel_on, left_leg_channel_on, right_arm_channel_on,
                           chest_one_channel_on, chest_two_channel_on,
                           `ECC_RSVD_FILL,
                           differential_input_select, gain_code,
                           `ECC_RSVD_FILL};

    // ======================================================================
    // Frame state machine
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (!cs_n_s) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // Early deselect drops the partial word unapplied
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end else if (word_done) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cs_n_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State, edge history and bit counter
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            sclk_d   <= 1'b1;
            bit_cnt  <= 6'h00;
            rx_shift <= 31'h0000_0000;
        end else if (ce) begin
            state  <= next_state;
            sclk_d <= sclk_s;
            if (state != ST_SHIFT) begin
                bit_cnt <= 6'h00;
            end else if (sclk_rise) begin
                bit_cnt  <= bit_cnt + 6'h01;
                rx_shift <= {rx_shift[29:0], sdi_s};
            end
        end
    end

    // ======================================================================
    // Register writes, applied only on a complete word
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            left_arm_channel_on       <= `ECC_RST_CHAN_ON;
            left_leg_channel_on       <= `ECC_RST_CHAN_ON;
            right_arm_channel_on      <= `ECC_RST_CHAN_ON;
            chest_one_channel_on      <= `ECC_RST_CHAN_ON;
            chest_two_channel_on      <= `ECC_RST_CHAN_ON;
            differential_input_select <= `ECC_RST_DIFF_SEL;
            gain_code                 <= `ECC_RST_GAIN;
        end else if (ce && word_done && is_write && cmd_addr == `ECC_ADDR_CHAN_CTRL) begin
            // Reserved bits of the data are simply not stored
            left_arm_channel_on       <= cmd_word[`ECC_BIT_LEFT_ARM];
            left_leg_channel_on       <= cmd_word[`ECC_BIT_LEFT_LEG];
            right_arm_channel_on      <= cmd_word[`ECC_BIT_RIGHT_ARM];
            chest_one_channel_on      <= cmd_word[`ECC_BIT_CHEST_ONE];
            chest_two_channel_on      <= cmd_word[`ECC_BIT_CHEST_TWO];
            differential_input_select <= cmd_word[`ECC_BIT_DIFF_SEL];
            gain_code                 <= cmd_word[`ECC_GAIN_MSB:`ECC_GAIN_LSB];
        end
    end

    // ======================================================================
    // Gain decode, registered so the outputs come from flops
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gain_tenths       <= `ECC_GAIN_X1P4;
            gain_cal_required <= 1'b0;
        end else if (ce) begin
            gain_cal_required <= (gain_code == `ECC_GAIN_CODE_3);
            case (gain_code)
                `ECC_GAIN_CODE_0: gain_tenths <= `ECC_GAIN_X1P4;
                `ECC_GAIN_CODE_1: gain_tenths <= `ECC_GAIN_X2P1;
                `ECC_GAIN_CODE_2: gain_tenths <= `ECC_GAIN_X2P8;
                default:          gain_tenths <= `ECC_GAIN_X4P2;
            endcase
        end
    end

    // ======================================================================
    // Read response: captured at the end of a read, shifted out next frame.
    // Any address other than the channel control answers zero data, since
    // respiration, pace and other registers have no storage in this block.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_word <= 32'h0000_0000;
        end else if (ce && word_done) begin
            if (!is_write && cmd_addr == `ECC_ADDR_CHAN_CTRL) begin
                tx_word <= {1'b0, cmd_addr, chan_ctrl_rd};
            end else if (!is_write) begin
                tx_word <= {1'b0, cmd_addr, 24'h00_0000};
            end else begin
                tx_word <= 32'h0000_0000;
            end
        end
    end

    // Output shifter; first bit appears at select, rest on falling edges
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_shift <= 32'h0000_0000;
            sdo      <= 1'b0;
            sdo_oe   <= 1'b0;
        end else if (ce) begin
            sdo_oe <= ~cs_n_s;
            if (state == ST_IDLE && !cs_n_s) begin
                tx_shift <= {tx_word[30:0], 1'b0};
                sdo      <= tx_word[31];
            end else if (state == ST_SHIFT && sclk_fall) begin
                tx_shift <= {tx_shift[30:0], 1'b0};
                sdo      <= tx_shift[31];
            end else if (cs_n_s) begin
                sdo <= 1'b0;
            end
        end
    end

endmodule // ecc_ctrl

// File: verification/ecc_ctrl_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the channel control block
module ecc_ctrl_sva (
    // Clock, reset, enable
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       ce,
    // Serial pins
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       sdo_oe,
    // Channel and front-end controls
    input wire logic       left_arm_channel_on,
    input wire logic       left_leg_channel_on,
    input wire logic       right_arm_channel_on,
    input wire logic       chest_one_channel_on,
    input wire logic       chest_two_channel_on,
    input wire logic       differential_input_select,
    input wire logic [1:0] gain_code,
    input wire logic [7:0] gain_tenths,
    input wire logic       gain_cal_required
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Controls packed as the register fields
    wire [7:0] ctl = {left_arm_channel_on, left_leg_channel_on, right_arm_channel_on,
                      chest_one_channel_on, chest_two_channel_on,
                      differential_input_select, gain_code};
    // Gain in tenths per code
    function automatic logic [7:0] tenths(input logic [1:0] c);
        return (c == 2'h0) ? 8'h0e : (c == 2'h1) ? 8'h15 : (c == 2'h2) ? 8'h1c : 8'h2a;
    endfunction
    // Pin sequences; four clocks covers the two-stage sync plus one register
    sequence sel_fall; $fell(cs_n); endsequence
    sequence idle_run; cs_n [*4]; endsequence
    sequence busy_run; !cs_n [*4]; endsequence
    sequence clk_high; (sclk && !cs_n) [*4]; endsequence
    // Six idle clocks fit inside the shortest gap the host leaves between frames
    sequence idle_long; cs_n [*6]; endsequence
    gain_map_a: assert property (gain_tenths == tenths($past(gain_code)))
        else $error("gain tenths wrong");
    cal_flag_a: assert property (gain_cal_required == ($past(gain_code) == 2'h3))
        else $error("calibration flag wrong");
    reset_vals_a: assert property ($rose(rstn) |-> ctl == 8'h00 && gain_tenths == 8'h0e)
        else $error("reset values wrong");
    oe_quiet_a: assert property (!sdo_oe |-> !sdo)
        else $error("sdo high while released");
    oe_follow_a: assert property (busy_run |-> sdo_oe)
        else $error("sdo not enabled in frame");
    oe_drop_a: assert property (idle_run |-> !sdo_oe)
        else $error("sdo enabled while idle");
    oe_rise_a: assert property (sel_fall |-> ##[1:4] sdo_oe)
        else $error("sdo enable late");
    sdo_hold_a: assert property (clk_high |-> $stable(sdo))
        else $error("sdo moved while clock high");
    ctl_quiet_a: assert property (idle_long |=> $stable(ctl))
        else $error("controls moved outside a frame");
endmodule // ecc_ctrl_sva

bind ecc_ctrl ecc_ctrl_sva chk (.sys_clk, .rstn, .ce, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
    .left_arm_channel_on, .left_leg_channel_on, .right_arm_channel_on,
    .chest_one_channel_on, .chest_two_channel_on, .differential_input_select,
    .gain_code, .gain_tenths, .gain_cal_required);

// File: verification/ecc_host.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the serial port, clock idles low
module ecc_host (
    // Clock
    input  wire logic        sys_clk,
    // Serial pins
    output logic        sclk,
    output logic        cs_n,
    output logic        sdi,
    input  wire logic        sdo,
    // Word shifted in, flagged for one clock
    output logic        done,
    output logic [31:0] rx
);
    localparam int HALF = 5; // Above the 4-clock minimum per phase
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
        done = 1'b0;
        rx   = 32'h0000_0000;
    end
    // One frame MSB first; fewer than 32 bits is an abort
    task automatic xfer(input logic [31:0] w, input int nb);
        int i;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        sdi  <= w[31];
        repeat (HALF) @(posedge sys_clk);
        for (i = 31; i > 31 - nb; i--) begin
            rx    <= {rx[30:0], sdo}; // MSB lands at the top after 32 shifts
            sclk  <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            sclk <= 1'b0;
            sdi  <= w[(i + 31) % 32];
            repeat (HALF) @(posedge sys_clk);
        end
        cs_n <= 1'b1;
        sdi  <= ~sdi; // Released line never holds its last bit
        done <= (nb == 32);
        @(posedge sys_clk);
        done <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule // ecc_host

// File: verification/tb.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the channel control block
module tb;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        ce      = 1'b1;
    wire         sclk, cs_n, sdi, sdo, sdo_oe, done, diff, cal;
    wire  [31:0] rx;
    wire  [4:0]  chans;
    wire  [1:0]  gcode;
    wire  [7:0]  tenths;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          k;
    logic [31:0] seed = 32'h1745_b22e;
    logic [31:0] exp_q[$];
    logic [23:0] reg_m = 24'h00_0000;
    logic [31:0] tx_m  = 32'h0000_0000;

    always #5 sys_clk = ~sys_clk;

    ecc_ctrl uut (.sys_clk, .rstn, .ce, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
        .left_arm_channel_on(chans[4]), .left_leg_channel_on(chans[3]),
        .right_arm_channel_on(chans[2]), .chest_one_channel_on(chans[1]),
        .chest_two_channel_on(chans[0]), .differential_input_select(diff),
        .gain_code(gcode), .gain_tenths(tenths), .gain_cal_required(cal));
    ecc_host host (.sys_clk, .sclk, .cs_n, .sdi, .sdo, .done, .rx);

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] gain_t(input logic [1:0] c);
        return (c == 2'h0) ? 8'h0e : (c == 2'h1) ? 8'h15 : (c == 2'h2) ? 8'h1c : 8'h2a;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Frame plus register model; reads answer in the following frame
    task automatic frame(input logic [31:0] w, input int nb);
        if (nb == 32) exp_q.push_back(tx_m);
        host.xfer(w, nb);
        // A cut frame never completes, so the pending answer survives it
        if (nb == 32) tx_m = 32'h0000_0000;
        if (nb == 32 && w[31] && w[30:24] == 7'h01) reg_m = w[23:0] & 24'hf8_0700;
        if (nb == 32 && !w[31]) tx_m = {1'b0, w[30:24], (w[30:24] == 7'h01) ? reg_m : 24'h0};
        @(negedge sys_clk);
        check({24'h0, chans, diff, gcode}, {24'h0, reg_m[23:19], reg_m[10:8]});
        check({24'h0, tenths}, {24'h0, gain_t(reg_m[9:8])});
        check({31'h0, cal}, {31'h0, reg_m[9:8] == 2'h3});
    endtask
    // Oldest expected word against each complete frame
    always @(posedge sys_clk) if (done === 1'b1) check(rx, exp_q.pop_front());

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Reset values, then every gain code with random fields; mapped addresses only
        frame(32'h0100_0000, 32);
        for (k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            frame({1'b1, 7'h01, seed[23:19], 8'h00, seed[10], k[1:0], seed[7:0]}, 32);
            frame(32'h0100_0000, 32);
        end
        // Reserved bits written as ones must read back zero
        frame(32'h81ff_ffff, 32);
        frame(32'h0100_0000, 32);
        // Aborted write, write elsewhere, reduced-variant register
        frame(32'h8100_0000, 20);
        frame(32'h8200_0000, 32);
        frame(32'h0300_0000, 32);
        frame(32'h0000_0000, 32);
        repeat (4) @(posedge sys_clk);
        wrap_up;
    end
    // Watchdog, roughly ten times the expected run
    initial begin
        #500_000;
        n_mismatch++;
        wrap_up;
    end
endmodule // tb
